//--- hw/pmg_guard.sv
`timescale 1ns/100ps
module pmg_guard #(
    parameter int WDG_CYCLES = pmg_pkg::WDG_CYC
) (
    input wire logic sys_clk_i, // System clock
    input wire logic resetn_i, // Sync reset, low
    input wire logic cfg_we_i, // Level table write
    input wire logic [2:0] cfg_src_lvl_i, // Level of writer
    input wire logic [2:0] cfg_lvl_i, // Level written
    input wire logic [15:0] cfg_base_i, // Range low
    input wire logic [15:0] cfg_limit_i, // Range high
    input wire logic [15:0] cfg_xlat_i, // Physical base
    input wire logic [2:0] cfg_perm_i, // Rights x,w,r
    output logic cfg_err_o, // Write refused
    input wire logic acc_req_i, // Access request
    input wire logic [15:0] acc_addr_i, // Virtual address
    input wire logic [2:0] acc_lvl_i, // Issuing level
    input wire logic [1:0] acc_kind_i, // Read/write/fetch
    input wire logic acc_internal_i, // Device-internal
    input wire logic acc_par_i, // Request parity
    output logic acc_grant_o, // Access allowed
    output logic acc_fault_o, // Access refused
    output logic [15:0] phys_addr_o, // Translated addr
    output logic phys_valid_o, // Translation valid
    input wire logic op_valid_i, // Opcode decoded
    input wire logic op_illegal_i, // Opcode illegal
    input wire logic bus_req_i, // Transfer start
    input wire logic bus_ack_i, // Transfer ack
    input wire logic ecc_single_i, // One-bit fault
    input wire logic ecc_multi_i, // Uncorrectable
    input wire logic ecc_crit_i, // Critical fault
    output logic ecc_fixed_o, // Fault corrected
    input wire logic wdg_en_i, // Watchdog enable
    input wire logic wdg_kick_i, // Checkpoint write
    input wire logic [7:0] wdg_chk_i, // Checkpoint value
    input wire logic trap_ack_i, // Trap taken
    output logic alarm_o, // Alarm pulse
    output logic sec_alarm_o, // Security alarm
    output logic sys_reset_o, // Forced reset
    output logic secure_o, // Secure state
    output logic trap_req_o, // Trap request
    output logic [2:0] trap_cause_o // Trap cause
);
    // ==========================================
    // Level table
    logic [15:0] base_q [pmg_pkg::NUM_LVL];
    logic [15:0] limit_q [pmg_pkg::NUM_LVL];
    logic [15:0] xlat_q [pmg_pkg::NUM_LVL];
    logic [2:0] perm_q [pmg_pkg::NUM_LVL];
    pmg_pkg::pmg_state_t state_q;
    logic run;
    logic src_os;
    logic src_app;
    logic cfg_ok;
    assign run = (state_q == pmg_pkg::ST_RUN);
    assign src_os = (cfg_src_lvl_i >= pmg_pkg::LVL_OS_LO) && (cfg_src_lvl_i <= pmg_pkg::LVL_OS_HI);
    assign src_app = (cfg_src_lvl_i >= pmg_pkg::LVL_APP_LO);
    assign cfg_ok = cfg_we_i && run && src_os && !src_app && (cfg_lvl_i > pmg_pkg::LVL_INT_HI);

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < pmg_pkg::NUM_LVL; i++) begin
                base_q[i] <= pmg_pkg::ADDR_ZERO;
                limit_q[i] <= pmg_pkg::ADDR_MAX;
                xlat_q[i] <= pmg_pkg::ADDR_ZERO;
                perm_q[i] <= (i <= int'(pmg_pkg::LVL_INT_HI)) ? pmg_pkg::PERM_ALL : pmg_pkg::PERM_NONE;
            end
        end else if (cfg_ok) begin
            base_q[cfg_lvl_i] <= cfg_base_i;
            limit_q[cfg_lvl_i] <= cfg_limit_i;
            xlat_q[cfg_lvl_i] <= cfg_xlat_i;
            perm_q[cfg_lvl_i] <= cfg_perm_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            cfg_err_o <= 1'b0;
        end else begin
            cfg_err_o <= cfg_we_i && !cfg_ok;
        end
    end

    // ==========================================
    // Access check, same cycle as the request
    logic in_range;
    logic perm_ok;
    logic lvl_bad;
    logic par_bad;
    logic viol;
    logic [2:0] p;
    assign p = perm_q[acc_lvl_i];
    assign in_range = (acc_addr_i >= base_q[acc_lvl_i]) && (acc_addr_i <= limit_q[acc_lvl_i]);
    always_comb begin
        unique case (acc_kind_i)
            pmg_pkg::KIND_RD: perm_ok = p[pmg_pkg::PERM_R];
            pmg_pkg::KIND_WR: perm_ok = p[pmg_pkg::PERM_W];
            pmg_pkg::KIND_FETCH: perm_ok = p[pmg_pkg::PERM_X];
            default: perm_ok = 1'b0;
        endcase
    end
    assign lvl_bad = (acc_lvl_i <= pmg_pkg::LVL_INT_HI) && !acc_internal_i;
    assign par_bad = (^{acc_addr_i, acc_lvl_i, acc_kind_i}) != acc_par_i;
    assign viol = acc_req_i && run && !par_bad && (lvl_bad || !in_range || !perm_ok);
    assign acc_grant_o = acc_req_i && run && !par_bad && !viol;

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            phys_addr_o <= pmg_pkg::ADDR_ZERO;
            phys_valid_o <= 1'b0;
            acc_fault_o <= 1'b0;
        end else begin
            phys_valid_o <= acc_grant_o;
            acc_fault_o <= acc_req_i && run && !acc_grant_o;
            if (acc_grant_o) begin
                phys_addr_o <= acc_addr_i - base_q[acc_lvl_i] + xlat_q[acc_lvl_i];
            end
        end
    end

    // ==========================================
    // Bus handshake monitor
    logic bus_busy_q;
    logic [4:0] bus_cnt_q;
    logic bus_err;
    assign bus_err = (bus_ack_i && !bus_busy_q && !bus_req_i)
                   || (bus_busy_q && !bus_ack_i && bus_cnt_q == 5'(pmg_pkg::BUS_CYC - 1));
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            bus_busy_q <= 1'b0;
            bus_cnt_q <= 5'h00;
        end else if (bus_ack_i || bus_err) begin
            bus_busy_q <= 1'b0;
            bus_cnt_q <= 5'h00;
        end else if (bus_req_i) begin
            bus_busy_q <= 1'b1;
            bus_cnt_q <= 5'h00;
        end else if (bus_busy_q) begin
            bus_cnt_q <= bus_cnt_q + 5'h01;
        end
    end

    // ==========================================
    // Watchdog and checkpoint
    logic [31:0] wdg_cnt_q;
    logic [7:0] chk_q;
    logic wdg_exp;
    logic flow_err;
    assign wdg_exp = wdg_en_i && run && !wdg_kick_i && (wdg_cnt_q == 32'(WDG_CYCLES - 1));
    assign flow_err = wdg_kick_i && run && (wdg_chk_i != chk_q);
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i || !wdg_en_i || wdg_kick_i || wdg_exp) begin
            wdg_cnt_q <= 32'h0000_0000;
        end else if (run) begin
            wdg_cnt_q <= wdg_cnt_q + 32'h0000_0001;
        end
    end
    // Resync on mismatch so one slip gives one trap
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            chk_q <= pmg_pkg::CHK_RESET;
        end else if (wdg_kick_i && run) begin
            chk_q <= wdg_chk_i + pmg_pkg::CHK_STEP;
        end
    end

    // ==========================================
    // Fault reaction
    logic sec_evt;
    logic trap_evt;
    logic [2:0] cause_d;
    logic [3:0] rst_cnt_q;
    assign sec_evt = (op_valid_i && op_illegal_i) || ecc_crit_i || (acc_req_i && par_bad);
    assign trap_evt = viol || wdg_exp || flow_err;
    always_comb begin
        if (viol) begin
            cause_d = pmg_pkg::CAUSE_ACCESS;
        end else if (wdg_exp) begin
            cause_d = pmg_pkg::CAUSE_WDG;
        end else begin
            cause_d = pmg_pkg::CAUSE_FLOW;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            state_q <= pmg_pkg::ST_RUN;
            rst_cnt_q <= 4'h0;
            trap_cause_o <= pmg_pkg::CAUSE_NONE;
        end else if (sec_evt) begin
            state_q <= pmg_pkg::ST_SECURE;
        end else begin
            unique case (state_q)
                pmg_pkg::ST_RUN: begin
                    if (trap_evt) begin
                        state_q <= pmg_pkg::ST_RST;
                        rst_cnt_q <= 4'(pmg_pkg::RST_CYC - 1);
                        trap_cause_o <= cause_d;
                    end
                end
                pmg_pkg::ST_RST: begin
                    if (rst_cnt_q == 4'h0) begin
                        state_q <= pmg_pkg::ST_TRAP;
                    end else begin
                        rst_cnt_q <= rst_cnt_q - 4'h1;
                    end
                end
                pmg_pkg::ST_TRAP: begin
                    if (trap_ack_i) begin
                        state_q <= pmg_pkg::ST_RUN;
                        trap_cause_o <= pmg_pkg::CAUSE_NONE;
                    end
                end
                pmg_pkg::ST_SECURE: begin
                    state_q <= pmg_pkg::ST_SECURE;
                end
            endcase
        end
    end
    assign sys_reset_o = (state_q == pmg_pkg::ST_RST) || (state_q == pmg_pkg::ST_SECURE);
    assign secure_o = (state_q == pmg_pkg::ST_SECURE);
    assign trap_req_o = (state_q == pmg_pkg::ST_TRAP);

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            ecc_fixed_o <= 1'b0;
            alarm_o <= 1'b0;
            sec_alarm_o <= 1'b0;
        end else begin
            ecc_fixed_o <= ecc_single_i && !ecc_multi_i && !ecc_crit_i;
            alarm_o <= bus_err || ecc_multi_i || wdg_exp || flow_err;
            sec_alarm_o <= sec_evt && !secure_o;
        end
    end

    // ==========================================
    // Assertions

    // Own count of cycles since a transfer started, so a slip in the monitor counter shows
    logic [4:0] mon_bus_q;
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i || bus_ack_i) begin
            mon_bus_q <= 5'h00;
        end else if (mon_bus_q == 5'(pmg_pkg::BUS_CYC)) begin
            mon_bus_q <= 5'h00;
        end else if (bus_req_i) begin
            mon_bus_q <= 5'h01;
        end else if (mon_bus_q != 5'h00) begin
            mon_bus_q <= mon_bus_q + 5'h01;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    a_reserved_cfg: assert property (cfg_we_i && cfg_lvl_i <= 3'h2 |=> cfg_err_o)
        else $error("reserved level write not refused");
    a_app_cfg: assert property (cfg_we_i && cfg_src_lvl_i >= 3'h5 |=> cfg_err_o)
        else $error("application config write not refused");
    a_reserved_acc: assert property (acc_req_i && acc_lvl_i <= 3'h2 && !acc_internal_i |-> !acc_grant_o)
        else $error("reserved level granted to software");
    a_range_deny: assert property (acc_grant_o |-> in_range && perm_ok)
        else $error("grant outside range or rights");
    a_viol_trap: assert property (viol |=> sys_reset_o [*8] ##1 trap_req_o)
        else $error("violation not reset then trapped");
    a_illegal_op: assert property (op_valid_i && op_illegal_i |=> secure_o && sys_reset_o)
        else $error("illegal opcode without security reset");
    a_bus_timeout: assert property (mon_bus_q == 5'(pmg_pkg::BUS_CYC) && !bus_ack_i |=> alarm_o)
        else $error("bus timeout without alarm");
    a_secure_hold: assert property (secure_o |=> secure_o && !acc_grant_o)
        else $error("secure state left");
    a_crit_alarm: assert property (ecc_crit_i && !secure_o |=> sec_alarm_o && secure_o)
        else $error("critical fault without security alarm");
    a_flow_check: assert property (flow_err |=> alarm_o ##1 trap_cause_o == 3'h5)
        else $error("checkpoint slip not reported");
    a_phys_xlat: assert property (acc_grant_o |=> phys_valid_o && phys_addr_o == $past(acc_addr_i)
        - $past(base_q[acc_lvl_i]) + $past(xlat_q[acc_lvl_i]))
        else $error("translation wrong");
    a_fault_pulse: assert property (viol |=> acc_fault_o && !phys_valid_o)
        else $error("violation without fault pulse");
    a_ecc_fix: assert property (ecc_single_i && !ecc_multi_i && !ecc_crit_i |=> ecc_fixed_o)
        else $error("single bit fault not corrected");
    a_wdg_trap: assert property (wdg_exp && !viol && !sec_evt |=> alarm_o && sys_reset_o && trap_cause_o == pmg_pkg::CAUSE_WDG)
        else $error("watchdog expiry not reported");
    c_bus_timeout: cover property (mon_bus_q == 5'(pmg_pkg::BUS_CYC));
    c_trap_done: cover property (trap_req_o ##1 trap_ack_i ##1 run);
    c_grant: cover property (acc_grant_o && acc_lvl_i >= 3'h5);
    c_secure: cover property (sec_alarm_o && secure_o);
    c_wdg: cover property (wdg_exp);
endmodule : pmg_guard

//--- hw/pmg_pkg.sv
// Notes on behaviour
// - Up to eight privilege levels, each user level with its own access rights.
// - Levels zero to two serve internal operations; software may not claim them.
// - Levels three and four belong to operating system code.
// - Levels five to seven belong to application code.
// - A permission breach forces a reset, then hands control to a trap routine.
// - Address against issuing level; mismatch or manipulation gives error and reaction.
// - An illegal opcode fetched or executed triggers a security reset.
// - Every bus transfer has a watched handshake; a failed one raises an alarm.
// - Single-bit faults are corrected; others alarm; critical ones alarm and reset.
// - Watchdog timer and checkpoint register check processing time and program flow.
// - An uncorrectable critical error raises a security alarm and enters secure state.
package pmg_pkg;
    // ==========================================
    // Widths and levels
    localparam int ADDR_W = 16;
    localparam int LVL_W = 3;
    localparam int NUM_LVL = 8;
    localparam int CHK_W = 8;
    localparam int CAUSE_W = 3;
    localparam logic [2:0] LVL_INT_HI = 3'h2;
    localparam logic [2:0] LVL_OS_LO = 3'h3;
    localparam logic [2:0] LVL_OS_HI = 3'h4;
    localparam logic [2:0] LVL_APP_LO = 3'h5;
    localparam logic [2:0] PERM_ALL = 3'h7;
    localparam logic [2:0] PERM_NONE = 3'h0;
    localparam int PERM_R = 0;
    localparam int PERM_W = 1;
    localparam int PERM_X = 2;
    localparam logic [1:0] KIND_RD = 2'h0;
    localparam logic [1:0] KIND_WR = 2'h1;
    localparam logic [1:0] KIND_FETCH = 2'h2;
    localparam logic [15:0] ADDR_MAX = 16'hffff;
    localparam logic [15:0] ADDR_ZERO = 16'h0000;
    localparam logic [7:0] CHK_RESET = 8'h00;
    localparam logic [7:0] CHK_STEP = 8'h01;
    // ==========================================
    // Trap causes
    localparam logic [2:0] CAUSE_NONE = 3'h0;
    localparam logic [2:0] CAUSE_ACCESS = 3'h1;
    localparam logic [2:0] CAUSE_WDG = 3'h4;
    localparam logic [2:0] CAUSE_FLOW = 3'h5;
    // ==========================================
    // Timing
    localparam int CLK_NS = 25;
    localparam int RST_NS = 200;
    localparam int RST_CYC = (RST_NS + CLK_NS - 1) / CLK_NS;
    localparam int BUS_NS = 400;
    localparam int BUS_CYC = BUS_NS / CLK_NS;
    localparam int WDG_US = 1000;
    localparam int WDG_CYC = WDG_US * 1000 / CLK_NS;
    typedef enum logic [1:0] {ST_RUN, ST_RST, ST_TRAP, ST_SECURE} pmg_state_t;
endpackage : pmg_pkg

//--- dv/pmg_core_model.sv
`timescale 1ns/100ps
module pmg_core_model (
    input wire logic sys_clk_i, // Clock
    input wire logic resetn_i, // Sync reset, low
    input wire logic drop_i, // Withhold bus acks
    input wire logic trap_req_i, // Trap request
    input wire logic bus_req_i, // Transfer start
    output logic trap_ack_o, // Trap taken
    output logic bus_ack_o // Transfer done
);
    logic [1:0] cnt_q;
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            trap_ack_o <= 1'b0;
        end else begin
            trap_ack_o <= trap_req_i && !trap_ack_o;
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            cnt_q <= 2'h0;
            bus_ack_o <= 1'b0;
        end else begin
            cnt_q <= bus_req_i ? 2'h2 : (cnt_q != 2'h0 ? cnt_q - 2'h1 : 2'h0);
            bus_ack_o <= (cnt_q == 2'h1) && !drop_i;
        end
    end
endmodule : pmg_core_model

//--- dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic sys_clk_i = 1'b0, resetn_i = 1'b0, cfg_we_i = 1'b0, acc_req_i = 1'b0, acc_internal_i = 1'b0;
    logic acc_par_i = 1'b0, op_valid_i = 1'b0, op_illegal_i = 1'b0, bus_req_i = 1'b0, drop = 1'b0;
    logic ecc_single_i = 1'b0, ecc_multi_i = 1'b0, ecc_crit_i = 1'b0, wdg_en_i = 1'b0, wdg_kick_i = 1'b0;
    logic [2:0] cfg_src_lvl_i = 3'h0, cfg_lvl_i = 3'h0, cfg_perm_i = 3'h0, acc_lvl_i = 3'h0;
    logic [15:0] cfg_base_i = 16'h0000, cfg_limit_i = 16'h0000, cfg_xlat_i = 16'h0000, acc_addr_i = 16'h0000;
    logic [1:0] acc_kind_i = 2'h0;
    logic [7:0] wdg_chk_i = 8'h00;
    logic bus_ack_i, trap_ack_i, cfg_err_o, acc_grant_o, acc_fault_o, phys_valid_o, ecc_fixed_o;
    logic alarm_o, sec_alarm_o, sys_reset_o, secure_o, trap_req_o;
    logic [15:0] phys_addr_o;
    logic [2:0] trap_cause_o;
    int err_total = 0, num_checks = 0, cycles = 0;
    always #12.5 sys_clk_i = ~sys_clk_i;
    // Short watchdog so the timeout case stays quick
    pmg_guard #(.WDG_CYCLES(64)) u_dut (
        .sys_clk_i, .resetn_i, .cfg_we_i, .cfg_src_lvl_i, .cfg_lvl_i, .cfg_base_i, .cfg_limit_i, .cfg_xlat_i,
        .cfg_perm_i, .cfg_err_o, .acc_req_i, .acc_addr_i, .acc_lvl_i, .acc_kind_i, .acc_internal_i, .acc_par_i,
        .acc_grant_o, .acc_fault_o, .phys_addr_o, .phys_valid_o, .op_valid_i, .op_illegal_i, .bus_req_i,
        .bus_ack_i, .ecc_single_i, .ecc_multi_i, .ecc_crit_i, .ecc_fixed_o, .wdg_en_i, .wdg_kick_i, .wdg_chk_i,
        .trap_ack_i, .alarm_o, .sec_alarm_o, .sys_reset_o, .secure_o, .trap_req_o, .trap_cause_o
    );
    pmg_core_model u_core (
        .sys_clk_i, .resetn_i, .drop_i(drop), .trap_req_i(trap_req_o), .bus_req_i, .trap_ack_o(trap_ack_i),
        .bus_ack_o(bus_ack_i)
    );
    // ==========================================
    // Reporting
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            stop_test();
        end
    end
    // ==========================================
    // Shared sequences
    // Entered at the first cycle of the forced reset
    task automatic rec(input logic [2:0] cause);
        int n;
        chk(sys_reset_o, 1'b1);
        chk(trap_cause_o, cause);
        repeat (7) begin
            @(posedge sys_clk_i);
            #1 chk(sys_reset_o, 1'b1);
        end
        @(posedge sys_clk_i);
        #1 chk(trap_req_o, 1'b1);
        chk(sys_reset_o, 1'b0);
        n = 0;
        while (trap_req_o !== 1'b0 && n < 8) begin
            @(posedge sys_clk_i);
            #1 n++;
        end
        chk(trap_cause_o, pmg_pkg::CAUSE_NONE);
    endtask : rec
    task automatic cfg(input logic [2:0] s, l, input logic [15:0] b, t, x, input logic [2:0] p, input logic e);
        @(posedge sys_clk_i);
        cfg_we_i <= 1'b1;
        cfg_src_lvl_i <= s;
        cfg_lvl_i <= l;
        cfg_base_i <= b;
        cfg_limit_i <= t;
        cfg_xlat_i <= x;
        cfg_perm_i <= p;
        @(posedge sys_clk_i);
        cfg_we_i <= 1'b0;
        #1 chk(cfg_err_o, e);
    endtask : cfg
    // A refused access with good parity must always run through the full reset and trap
    task automatic acc(input logic [15:0] a, input logic [2:0] l, input logic [1:0] k, input logic i, g,
                       input logic [15:0] pa);
        @(posedge sys_clk_i);
        acc_req_i <= 1'b1;
        acc_addr_i <= a;
        acc_lvl_i <= l;
        acc_kind_i <= k;
        acc_internal_i <= i;
        acc_par_i <= ^{a, l, k};
        #1 chk(acc_grant_o, g);
        @(posedge sys_clk_i);
        acc_req_i <= 1'b0;
        #1 chk(phys_valid_o, g);
        chk(acc_fault_o, !g);
        if (g && l > pmg_pkg::LVL_INT_HI) chk(phys_addr_o, pa);
        if (!g) rec(pmg_pkg::CAUSE_ACCESS);
    endtask : acc
    // ==========================================
    // Scenarios
    task automatic t_table;
        @(posedge sys_clk_i);
        #1 chk({secure_o, sys_reset_o, trap_cause_o}, 16'h0000);
        // operating system sets up user levels
        cfg(3'h3, 3'h5, 16'h1000, 16'h1fff, 16'h8000, 3'h1, 1'b0);
        cfg(3'h4, 3'h6, 16'h3000, 16'h3fff, 16'h0100, 3'h4, 1'b0);
        cfg(3'h5, 3'h7, 16'h0000, 16'hffff, 16'h0000, 3'h7, 1'b1);
        cfg(3'h3, 3'h1, 16'h0000, 16'hffff, 16'h0000, 3'h7, 1'b1);
        cfg(3'h0, 3'h3, 16'h0000, 16'hffff, 16'h0000, 3'h7, 1'b1);
        acc(16'h1004, 3'h5, pmg_pkg::KIND_RD, 1'b0, 1'b1, 16'h8004);
        acc(16'h1fff, 3'h5, pmg_pkg::KIND_RD, 1'b0, 1'b1, 16'h8fff);
        acc(16'h2000, 3'h5, pmg_pkg::KIND_RD, 1'b0, 1'b0, 16'h0000);
        acc(16'h1004, 3'h5, pmg_pkg::KIND_WR, 1'b0, 1'b0, 16'h0000);
        acc(16'h3010, 3'h6, pmg_pkg::KIND_FETCH, 1'b0, 1'b1, 16'h0110);
        acc(16'h3010, 3'h6, pmg_pkg::KIND_RD, 1'b0, 1'b0, 16'h0000);
        acc(16'h1004, 3'h3, pmg_pkg::KIND_RD, 1'b0, 1'b0, 16'h0000);
        acc(16'h5555, 3'h0, pmg_pkg::KIND_WR, 1'b1, 1'b1, 16'h0000);
        acc(16'h5555, 3'h2, pmg_pkg::KIND_RD, 1'b0, 1'b0, 16'h0000);
        acc(16'h1004, 3'h5, 2'h3, 1'b0, 1'b0, 16'h0000);
    endtask : t_table
    task automatic t_bus(input logic d, input logic [15:0] exp);
        logic [15:0] n;
        @(posedge sys_clk_i);
        drop <= d;
        bus_req_i <= 1'b1;
        @(posedge sys_clk_i);
        bus_req_i <= 1'b0;
        n = 16'h0000;
        do begin
            @(posedge sys_clk_i);
            #1 n++;
        end while (alarm_o !== 1'b1 && n < 16'h0014);
        chk(n, exp);
    endtask : t_bus
    task automatic t_ecc(input logic s, m);
        @(posedge sys_clk_i);
        ecc_single_i <= s;
        ecc_multi_i <= m;
        @(posedge sys_clk_i);
        ecc_single_i <= 1'b0;
        ecc_multi_i <= 1'b0;
        #1 chk(ecc_fixed_o, s && !m);
        chk(alarm_o, m);
    endtask : t_ecc
    task automatic kick(input logic [7:0] v, input logic a);
        @(posedge sys_clk_i);
        wdg_kick_i <= 1'b1;
        wdg_chk_i <= v;
        @(posedge sys_clk_i);
        wdg_kick_i <= 1'b0;
        #1 chk(alarm_o, a);
    endtask : kick
    task automatic t_wdg;
        int n;
        @(posedge sys_clk_i);
        wdg_en_i <= 1'b1;
        kick(8'h00, 1'b0);
        kick(8'h01, 1'b0);
        kick(8'h05, 1'b1);
        rec(pmg_pkg::CAUSE_FLOW);
        kick(8'h06, 1'b0);
        n = 0;
        do begin
            @(posedge sys_clk_i);
            #1 n++;
        end while (trap_cause_o !== pmg_pkg::CAUSE_WDG && n < 100);
        chk(n >= 62 && n <= 66, 1'b1);
        rec(pmg_pkg::CAUSE_WDG);
        @(posedge sys_clk_i);
        wdg_en_i <= 1'b0;
    endtask : t_wdg
    // Illegal opcode, critical fault, tampered request; each needs an outside reset
    task automatic t_sec(input int i);
        @(posedge sys_clk_i);
        op_valid_i <= (i == 0);
        op_illegal_i <= (i == 0);
        ecc_crit_i <= (i == 1);
        acc_req_i <= (i == 2);
        acc_addr_i <= 16'h1004;
        acc_lvl_i <= 3'h5;
        acc_kind_i <= pmg_pkg::KIND_RD;
        acc_par_i <= 1'b1;
        @(posedge sys_clk_i);
        op_valid_i <= 1'b0;
        op_illegal_i <= 1'b0;
        ecc_crit_i <= 1'b0;
        acc_req_i <= 1'b0;
        #1 chk(sys_reset_o, 1'b1);
        chk(sec_alarm_o, 1'b1);
        @(posedge sys_clk_i);
        #1 chk({sec_alarm_o, secure_o}, 16'h0001);
        @(posedge sys_clk_i);
        resetn_i <= 1'b0;
        @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        #1 chk(secure_o, 1'b0);
    endtask : t_sec
    initial begin
        repeat (6) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        t_table();
        t_bus(1'b0, 16'h0014);
        t_bus(1'b1, 16'h0010);
        t_ecc(1'b1, 1'b0);
        t_ecc(1'b1, 1'b1);
        t_wdg();
        for (int i = 0; i < 3; i++) t_sec(i);
        stop_test();
    end
endmodule : tb_top
